// [logic/cpc_pkg.sv]
// constants, encodings and request carriers of the capture/compare module
package cpc_pkg;

   localparam int          NUM_UNITS = 2;
   localparam int          CNT_W     = 16;

   // counter and subunit register reset values, counter limit and step, forced capture value
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CNT_ONE   = 16'h0001;
   localparam logic [15:0] CMP_RST   = 16'h0000;
   localparam logic [15:0] CAP_RST   = 16'h0000;
   localparam logic [15:0] CAP_FORCE = 16'hFFFF;
   localparam logic [7:0]  FLAG_RST  = 8'h00;
   localparam logic [7:0]  MODE_RST  = 8'h00;
   localparam logic [7:0]  RD_RST    = 8'h00;

   // subunit_flag_register bit positions
   localparam int FLG_OFL = 0;
   localparam int FLG_CAP = 1;
   localparam int FLG_CMP = 2;
   localparam int FLG_RCR = 3;
   localparam int FLG_LAC = 4;
   localparam int FLG_OVR = 5;

   // subunit_mode_register field positions
   localparam int MOD_OAM = 0;
   localparam int MOD_IAM = 2;
   localparam int MOD_FOL = 4;
   localparam int MOD_MSK = 5;

   // prescaler reset and step, and masks per clock select code, counts of cycles minus one
   localparam logic [11:0] PRE_RST   = 12'h000;
   localparam logic [11:0] PRE_ONE   = 12'h001;
   localparam logic [11:0] PRE_MASK0 = 12'h000;
   localparam logic [11:0] PRE_MASK1 = 12'h00F;
   localparam logic [11:0] PRE_MASK2 = 12'h0FF;
   localparam logic [11:0] PRE_MASK3 = 12'hFFF;

   typedef enum logic [1:0] {
      OA_NONE   = 2'b00,
      OA_HIGH   = 2'b01,
      OA_LOW    = 2'b10,
      OA_TOGGLE = 2'b11
   } cpc_oam_e;

   typedef enum logic [1:0] {
      IA_NONE = 2'b00,
      IA_RISE = 2'b01,
      IA_FALL = 2'b10,
      IA_BOTH = 2'b11
   } cpc_iam_e;

   typedef enum logic [2:0] {
      RD_CNT_LO = 3'h0,
      RD_CNT_HI = 3'h1,
      RD_CAP_LO = 3'h2,
      RD_CAP_HI = 3'h3,
      RD_FLAG   = 3'h4,
      RD_MODE   = 3'h5
   } cpc_rsel_e;

   typedef enum logic [1:0] {
      WR_CMP_LO = 2'h0,
      WR_CMP_HI = 2'h1,
      WR_FLAG   = 2'h2,
      WR_MODE   = 2'h3
   } cpc_wsel_e;

   typedef struct packed {
      logic      stb;
      logic      unit;
      cpc_rsel_e sel;
   } cpc_rd_req_s;

   typedef struct packed {
      logic       stb;
      logic       unit;
      cpc_wsel_e  sel;
      logic [7:0] data;
   } cpc_wr_req_s;

endpackage

// [logic/cpc_edge_detect.sv]
// input synchroniser and edge qualifier of one subunit
`timescale 1ns/10ps
`default_nettype none
module cpc_edge_detect (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // pin and mode
   input  wire logic              pinAsync,
   input  wire cpc_pkg::cpc_iam_e edgeMode,
   // qualified event
   output wire logic              edgeEvt
);

   logic syncA_reg;
   logic syncB_reg;
   logic prev_reg;
   logic rise;
   logic fall;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         syncA_reg <= pinAsync;
         syncB_reg <= syncA_reg;
         prev_reg  <= syncB_reg;
      end
   end

   assign rise = syncB_reg & ~prev_reg;
   assign fall = ~syncB_reg & prev_reg;

   assign edgeEvt = ((edgeMode == cpc_pkg::IA_RISE) & rise) |
                    ((edgeMode == cpc_pkg::IA_FALL) & fall) |
                    ((edgeMode == cpc_pkg::IA_BOTH) & (rise | fall));

endmodule // cpc_edge_detect
`default_nettype wire

// [logic/cpc_capture_compare_module.sv]
// shared up counter with two capture/compare subunits
`timescale 1ns/10ps
`default_nettype none
module cpc_capture_compare_module (
   // clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                resetn,
   // control
   input  wire logic                                moduleEnable,
   input  wire logic [1:0]                          clockSelect,
   // byte read port
   input  wire cpc_pkg::cpc_rd_req_s                rdReq,
   output logic      [7:0]                          rdData,
   // byte write port
   input  wire cpc_pkg::cpc_wr_req_s                wrReq,
   // pins
   input  wire logic [cpc_pkg::NUM_UNITS-1:0]       capturePin,
   output wire logic [cpc_pkg::NUM_UNITS-1:0]       comparePin,
   // interrupt sources
   output logic                                     counterOverflowIrq,
   output wire logic [cpc_pkg::NUM_UNITS-1:0]       subunitOrIrq,
   output wire logic [cpc_pkg::NUM_UNITS-1:0]       subunitCompareIrq
);

   localparam int NU = cpc_pkg::NUM_UNITS;

   // shared counter state
   logic [11:0] preCnt_reg;
   logic [11:0] preMask;
   logic        tick;
   logic [15:0] cnt_reg;
   logic        cntUpd_reg;
   logic [7:0]  cntHiLatch_reg;
   logic        ovfEvt;

   // per unit views for the read mux
   logic [15:0] capView   [NU];
   logic [7:0]  capHiView [NU];
   logic [7:0]  flagView  [NU];
   logic [7:0]  modeView  [NU];

   // prescaler mask per clock select
   always_comb begin
      unique case (clockSelect)
         2'b00:   preMask = cpc_pkg::PRE_MASK0;
         2'b01:   preMask = cpc_pkg::PRE_MASK1;
         2'b10:   preMask = cpc_pkg::PRE_MASK2;
         2'b11:   preMask = cpc_pkg::PRE_MASK3;
      endcase
   end

   // a tick needs every masked low bit of the prescaler at one
   assign tick = moduleEnable & ((preCnt_reg & preMask) == preMask);

   always_ff @(posedge core_clk) begin
      if (!resetn || !moduleEnable) begin
         preCnt_reg <= cpc_pkg::PRE_RST;
      end else begin
         preCnt_reg <= preCnt_reg + cpc_pkg::PRE_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || !moduleEnable) begin
         cnt_reg <= cpc_pkg::CNT_RST;
      end else if (tick) begin
         cnt_reg <= cnt_reg + cpc_pkg::CNT_ONE;
      end
   end

   // marks the cycle right after the counter took a new value
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cntUpd_reg <= 1'b0;
      end else begin
         cntUpd_reg <= tick;
      end
   end

   assign ovfEvt = tick & (cnt_reg == cpc_pkg::CNT_MAX);

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         counterOverflowIrq <= 1'b0;
      end else begin
         counterOverflowIrq <= ovfEvt;
      end
   end

   // high byte latched on low read
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cntHiLatch_reg <= cpc_pkg::RD_RST;
      end else if (rdReq.stb && rdReq.sel == cpc_pkg::RD_CNT_LO) begin
         cntHiLatch_reg <= cnt_reg[15:8];
      end
   end

   // registered read data
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdData <= cpc_pkg::RD_RST;
      end else if (rdReq.stb) begin
         unique case (rdReq.sel)
            cpc_pkg::RD_CNT_LO: rdData <= cnt_reg[7:0];
            cpc_pkg::RD_CNT_HI: rdData <= cntHiLatch_reg;
            cpc_pkg::RD_CAP_LO: rdData <= capView[rdReq.unit][7:0];
            cpc_pkg::RD_CAP_HI: rdData <= capHiView[rdReq.unit];
            cpc_pkg::RD_FLAG:   rdData <= flagView[rdReq.unit];
            cpc_pkg::RD_MODE:   rdData <= modeView[rdReq.unit];
            default:            rdData <= cpc_pkg::RD_RST;
         endcase
      end
   end

   for (genvar u = 0; u < NU; u++) begin : g_unit

      localparam logic UNIT = 1'(u);

      logic [15:0] cmp_reg;
      logic [7:0]  cmpLoTmp_reg;
      logic        cmpLoPend_reg;
      logic [15:0] cap_reg;
      logic [7:0]  capHi_reg;
      logic        capRdPend_reg;
      logic        ofl_reg;
      logic        cmpFlag_reg;
      logic [1:0]  capCnt_reg;
      logic        rcr_reg;
      logic        lac_reg;
      logic        locked_reg;
      logic [7:0]  mode_reg;
      logic        pin_reg;
      logic        cmpIrq_reg;
      logic        orIrq_reg;

      logic        wrHit;
      logic        rdHit;
      logic        edgeEvt;
      logic        capEvt;
      logic        matchEvt;
      logic        capClr;
      logic        oflClr;
      logic        cmpClr;
      logic [2:0]  pend;
      cpc_pkg::cpc_oam_e output_action_select;

      assign wrHit = wrReq.stb & (wrReq.unit == UNIT);
      assign rdHit = rdReq.stb & (rdReq.unit == UNIT);
      assign output_action_select   = cpc_pkg::cpc_oam_e'(mode_reg[cpc_pkg::MOD_OAM +: 2]);

      cpc_edge_detect u_edge (
         .core_clk (core_clk),
         .resetn   (resetn),
         .pinAsync (capturePin[u]),
         .edgeMode (cpc_pkg::cpc_iam_e'(mode_reg[cpc_pkg::MOD_IAM +: 2])),
         .edgeEvt  (edgeEvt)
      );

      // capture only while active and unlocked
      assign capEvt = moduleEnable & edgeEvt & ~locked_reg;

      // match on a fresh counter value, not while suspended
      assign matchEvt = moduleEnable & cntUpd_reg & (cnt_reg == cmp_reg) &
                        ~cmpLoPend_reg & ~capRdPend_reg;

      always_ff @(posedge core_clk) begin
         if (!resetn || !moduleEnable) begin
            cmp_reg       <= cpc_pkg::CMP_RST;
            cmpLoTmp_reg  <= cpc_pkg::RD_RST;
            cmpLoPend_reg <= 1'b0;
         end else if (wrHit && wrReq.sel == cpc_pkg::WR_CMP_LO) begin
            cmpLoTmp_reg  <= wrReq.data;
            cmpLoPend_reg <= 1'b1;
         end else if (wrHit && wrReq.sel == cpc_pkg::WR_CMP_HI) begin
            cmp_reg       <= {wrReq.data, cmpLoTmp_reg};
            cmpLoPend_reg <= 1'b0;
         end
      end

      always_ff @(posedge core_clk) begin
         if (!resetn || !moduleEnable) begin
            cap_reg <= cpc_pkg::CAP_RST;
         end else if (rcr_reg) begin
            cap_reg <= cpc_pkg::CAP_FORCE;
         end else if (capEvt) begin
            cap_reg <= cnt_reg;
         end
      end

      // coherent capture read, compare suspended between the two reads
      always_ff @(posedge core_clk) begin
         if (!resetn || !moduleEnable) begin
            capHi_reg     <= cpc_pkg::RD_RST;
            capRdPend_reg <= 1'b0;
         end else if (rdHit && rdReq.sel == cpc_pkg::RD_CAP_LO) begin
            capHi_reg     <= cap_reg[15:8];
            capRdPend_reg <= 1'b1;
         end else if (rdHit && rdReq.sel == cpc_pkg::RD_CAP_HI) begin
            capRdPend_reg <= 1'b0;
         end
      end

      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            mode_reg <= cpc_pkg::MODE_RST;
         end else if (wrHit && wrReq.sel == cpc_pkg::WR_MODE) begin
            mode_reg <= wrReq.data;
         end
      end

      // lock after capture, released by any mode write; a capture wins
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            locked_reg <= 1'b0;
         end else if (capEvt && lac_reg) begin
            locked_reg <= 1'b1;
         end else if (wrHit && wrReq.sel == cpc_pkg::WR_MODE) begin
            locked_reg <= 1'b0;
         end
      end

      // control bits of the flag register
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            rcr_reg <= 1'b0;
            lac_reg <= 1'b0;
         end else if (wrHit && wrReq.sel == cpc_pkg::WR_FLAG) begin
            rcr_reg <= wrReq.data[cpc_pkg::FLG_RCR];
            lac_reg <= wrReq.data[cpc_pkg::FLG_LAC];
         end
      end

      // write one clears; a set in the same cycle wins
      assign oflClr = wrHit & (wrReq.sel == cpc_pkg::WR_FLAG) & wrReq.data[cpc_pkg::FLG_OFL];
      assign cmpClr = wrHit & (wrReq.sel == cpc_pkg::WR_FLAG) & wrReq.data[cpc_pkg::FLG_CMP];

      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            ofl_reg     <= 1'b0;
            cmpFlag_reg <= 1'b0;
         end else begin
            if (ovfEvt) begin
               ofl_reg <= 1'b1;
            end else if (oflClr) begin
               ofl_reg <= 1'b0;
            end
            if (matchEvt) begin
               cmpFlag_reg <= 1'b1;
            end else if (cmpClr) begin
               cmpFlag_reg <= 1'b0;
            end
         end
      end

      // capture flag counts up to an overrun state, each clear steps down
      assign capClr = wrHit & (wrReq.sel == cpc_pkg::WR_FLAG) & wrReq.data[cpc_pkg::FLG_CAP];

      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            capCnt_reg <= 2'h0;
         end else if (capEvt) begin
            capCnt_reg <= (capCnt_reg == 2'h0 || capClr) ? 2'h1 : 2'h2;
         end else if (capClr && capCnt_reg != 2'h0) begin
            capCnt_reg <= capCnt_reg - 2'h1;
         end
      end

      // force is static: it overrides matches, and with toggle it bursts every clock
      // output action with static force
      always_ff @(posedge core_clk) begin
         if (!resetn || !moduleEnable) begin
            pin_reg <= 1'b0;
         end else if (mode_reg[cpc_pkg::MOD_FOL] || matchEvt) begin
            unique case (output_action_select)
               cpc_pkg::OA_NONE:   pin_reg <= pin_reg;
               cpc_pkg::OA_HIGH:   pin_reg <= 1'b1;
               cpc_pkg::OA_LOW:    pin_reg <= 1'b0;
               cpc_pkg::OA_TOGGLE: pin_reg <= ~pin_reg;
            endcase
         end
      end

      assign pend = {cmpFlag_reg, (capCnt_reg != 2'h0), ofl_reg};

      // masked or source and direct compare source
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            cmpIrq_reg <= 1'b0;
            orIrq_reg  <= 1'b0;
         end else begin
            cmpIrq_reg <= matchEvt;
            orIrq_reg  <= |(pend & mode_reg[cpc_pkg::MOD_MSK +: 3]);
         end
      end

      assign comparePin[u]        = pin_reg;
      assign subunitCompareIrq[u] = cmpIrq_reg;
      assign subunitOrIrq[u]      = orIrq_reg;

      assign capView[u]   = cap_reg;
      assign capHiView[u] = capHi_reg;
      assign modeView[u]  = mode_reg;
      assign flagView[u]  = {2'b00, (capCnt_reg == 2'h2), lac_reg, rcr_reg,
                             cmpFlag_reg, (capCnt_reg != 2'h0), ofl_reg};

   end

endmodule // cpc_capture_compare_module
`default_nettype wire

// [tb/cpc_pin_model.sv]
// external pin model: drives capture inputs, samples compare outputs
`timescale 1ns/10ps
`default_nettype none
module cpc_pin_model (
   // clock
   input  wire logic       core_clk,
   // pins
   output var  logic [1:0] capturePin,
   input  wire logic [1:0] comparePin
);
   logic [1:0] pinSeen;
   // inputs rest low from time zero, before any enable
   initial capturePin = 2'h0;
   always @(posedge core_clk) pinSeen <= comparePin;
   // edge just after a clock edge, then time to pass the synchroniser
   task automatic drive(input int u, input logic lvl);
      @(posedge core_clk);
      #1 capturePin[u] = lvl;
      repeat (8) @(posedge core_clk);
   endtask
endmodule // cpc_pin_model
`default_nettype wire

// [tb/cpc_capture_compare_module_monitor.sv]
// port checker of the capture/compare module
`timescale 1ns/10ps
`default_nettype none
module cpc_capture_compare_module_monitor (
   // clock and reset
   input wire logic                 core_clk,
   input wire logic                 resetn,
   // control and access
   input wire logic                 moduleEnable,
   input wire logic [1:0]           clockSelect,
   input wire cpc_pkg::cpc_rd_req_s rdReq,
   input wire logic [7:0]           rdData,
   input wire cpc_pkg::cpc_wr_req_s wrReq,
   // pins and interrupts
   input wire logic [1:0]           capturePin,
   input wire logic [1:0]           comparePin,
   input wire logic                 counterOverflowIrq,
   input wire logic [1:0]           subunitOrIrq,
   input wire logic [1:0]           subunitCompareIrq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [1:0] lastOam_reg;
   logic       loPend_reg;
   // output action last written to unit 0
   always_ff @(posedge core_clk) begin
      if (!resetn)
         lastOam_reg <= 2'h0;
      else if (wrReq.stb && !wrReq.unit && wrReq.sel == cpc_pkg::WR_MODE)
         lastOam_reg <= wrReq.data[1:0];
   end
   // unit 0 compare low byte written, high byte still owed
   always_ff @(posedge core_clk) begin
      if (!resetn || !moduleEnable)
         loPend_reg <= 1'b0;
      else if (wrReq.stb && !wrReq.unit && wrReq.sel == cpc_pkg::WR_CMP_LO)
         loPend_reg <= 1'b1;
      else if (wrReq.stb && !wrReq.unit && wrReq.sel == cpc_pkg::WR_CMP_HI)
         loPend_reg <= 1'b0;
   end
   sequence standbyHeld;
      !moduleEnable [*3];
   endsequence
   sequence cntLoRead;
      rdReq.stb && rdReq.sel == cpc_pkg::RD_CNT_LO;
   endsequence
   chk_ovf_one_cycle: assert property (counterOverflowIrq |=> !counterOverflowIrq)
      else $error("overflow pulse too long");
   chk_standby_no_ovf: assert property (standbyHeld |-> !counterOverflowIrq)
      else $error("overflow in standby");
   chk_standby_no_match: assert property (standbyHeld |-> subunitCompareIrq == 2'h0)
      else $error("match in standby");
   chk_standby_pin_low: assert property (standbyHeld |-> comparePin == 2'h0)
      else $error("output pin active in standby");
   chk_standby_cnt_zero: assert property (standbyHeld ##0 cntLoRead ##1 !moduleEnable |-> ##1 rdData == 8'h00)
      else $error("counter not zero in standby");
   chk_read_holds: assert property (!rdReq.stb ##1 !rdReq.stb |=> $stable(rdData))
      else $error("read data moved without a read");
   chk_match_pulse: assert property (subunitCompareIrq != 2'h0 |=> subunitCompareIrq == 2'h0)
      else $error("match pulse too long");
   chk_match_level: assert property (subunitCompareIrq[0] && lastOam_reg[0] != lastOam_reg[1]
                                     |-> comparePin[0] == lastOam_reg[0])
      else $error("wrong level after match");
   chk_match_toggle: assert property (subunitCompareIrq[0] && lastOam_reg == 2'h3
                                      |-> comparePin[0] != $past(comparePin[0]))
      else $error("no toggle after match");
   chk_cmp_suspended: assert property (loPend_reg |=> !subunitCompareIrq[0])
      else $error("match while compare write incomplete");
endmodule // cpc_capture_compare_module_monitor
bind cpc_capture_compare_module cpc_capture_compare_module_monitor u_monitor (
   .core_clk(core_clk), .resetn(resetn), .moduleEnable(moduleEnable), .clockSelect(clockSelect),
   .rdReq(rdReq), .rdData(rdData), .wrReq(wrReq), .capturePin(capturePin), .comparePin(comparePin),
   .counterOverflowIrq(counterOverflowIrq), .subunitOrIrq(subunitOrIrq), .subunitCompareIrq(subunitCompareIrq));
`default_nettype wire

// [tb/cpc_capture_compare_module_bench.sv]
// self-checking bench of the capture/compare module
`timescale 1ns/10ps
`default_nettype none
module cpc_capture_compare_module_bench;
   logic                 core_clk;
   logic                 resetn;
   logic                 moduleEnable;
   logic [1:0]           clockSelect;
   cpc_pkg::cpc_rd_req_s rdReq;
   logic [7:0]           rdData;
   cpc_pkg::cpc_wr_req_s wrReq;
   logic [1:0]           capturePin;
   logic [1:0]           comparePin;
   logic                 counterOverflowIrq;
   logic [1:0]           subunitOrIrq;
   logic [1:0]           subunitCompareIrq;
   int                   fails;
   int                   num_checks;
   int                   cycles;
   int                   ovfCount;
   int                   cmpCount;
   logic [15:0]          v0;
   logic [15:0]          v1;
   logic [15:0]          v2;
   logic [7:0]           b;
   cpc_capture_compare_module DUT (.core_clk(core_clk), .resetn(resetn), .moduleEnable(moduleEnable),
      .clockSelect(clockSelect), .rdReq(rdReq), .rdData(rdData), .wrReq(wrReq), .capturePin(capturePin),
      .comparePin(comparePin), .counterOverflowIrq(counterOverflowIrq), .subunitOrIrq(subunitOrIrq),
      .subunitCompareIrq(subunitCompareIrq));
   cpc_pin_model pins (.core_clk(core_clk), .capturePin(capturePin), .comparePin(comparePin));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (counterOverflowIrq === 1'b1)
         ovfCount++;
      if (subunitCompareIrq[0] === 1'b1)
         cmpCount++;
      if (cycles == 90000) begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic u, input logic [2:0] s, output logic [7:0] d);
      @(posedge core_clk);
      #1 rdReq = '{stb: 1'b1, unit: u, sel: cpc_pkg::cpc_rsel_e'(s)};
      @(posedge core_clk);
      #1 rdReq.stb = 1'b0;
      @(posedge core_clk);
      #1 d = rdData;
   endtask
   // low byte always fetched before high byte
   task automatic rd16(input logic u, input logic [2:0] lo, output logic [15:0] d);
      logic [7:0] l;
      logic [7:0] h;
      rd(u, lo, l);
      rd(u, lo + 3'h1, h);
      d = {h, l};
   endtask
   task automatic wr(input logic u, input logic [1:0] s, input logic [7:0] d);
      @(posedge core_clk);
      #1 wrReq = '{stb: 1'b1, unit: u, sel: cpc_pkg::cpc_wsel_e'(s), data: d};
      @(posedge core_clk);
      #1 wrReq.stb = 1'b0;
   endtask
   task automatic wrCmp(input logic u, input logic [15:0] v);
      wr(u, 2'h0, v[7:0]);
      wr(u, 2'h1, v[15:8]);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      moduleEnable = 1'b0;
      clockSelect = 2'h0;
      rdReq = '0;
      wrReq = '0;
      repeat (10) @(posedge core_clk);
      #1 resetn = 1'b1;
      repeat (20) @(posedge core_clk);
      rd16(1'b0, 3'h0, v0);
      chk(v0, cpc_pkg::CNT_RST);
      rd(1'b1, 3'h4, b);
      chk(b, cpc_pkg::FLAG_RST);
      // toggle mode with compare mask, compare write dropped in standby
      wr(1'b1, 2'h3, 8'h83);
      wrCmp(1'b1, 16'h0030);
      rd(1'b1, 3'h5, b);
      chk(b, 8'h83);
      moduleEnable = 1'b1;
      repeat (100) @(posedge core_clk);
      chk(pins.pinSeen[1], 1'b0);
      rd(1'b1, 3'h4, b);
      chk(b[2], 1'b0);
      rd16(1'b0, 3'h0, v0);
      rd16(1'b0, 3'h0, v1);
      chk(v1 - v0, 16'h0006);
      cmpCount = 0;
      // high, low, toggle on unit 0
      for (int i = 0; i < 3; i++) begin
         wr(1'b0, 2'h3, 8'h81 + 8'(i));
         rd16(1'b0, 3'h0, v0);
         wrCmp(1'b0, v0 + 16'h0040);
         repeat (80) @(posedge core_clk);
         chk(pins.pinSeen[0], i != 1);
         chk(subunitOrIrq[0], 1'b1);
         rd(1'b0, 3'h4, b);
         chk(b, 8'h04);
         wr(1'b0, 2'h2, 8'h04);
         rd(1'b0, 3'h4, b);
         chk(b, 8'h00);
      end
      chk(16'(cmpCount), 16'h0003);
      // low byte only: matching stays suspended past the old compare value
      rd16(1'b0, 3'h0, v0);
      v1 = v0 + 16'h0040;
      wrCmp(1'b0, v1);
      wr(1'b0, 2'h0, v1[7:0]);
      repeat (80) @(posedge core_clk);
      rd(1'b0, 3'h4, b);
      chk(b[2], 1'b0);
      chk(pins.pinSeen[0], 1'b1);
      wr(1'b0, 2'h1, v1[15:8]);
      chk(16'(cmpCount), 16'h0003);
      // static force drives low, then high, without a match
      wr(1'b0, 2'h3, 8'h12);
      repeat (3) @(posedge core_clk);
      chk(pins.pinSeen[0], 1'b0);
      wr(1'b0, 2'h3, 8'h11);
      repeat (3) @(posedge core_clk);
      chk(pins.pinSeen[0], 1'b1);
      // rise, fall and both on unit 1, each with a rise then a fall
      for (int i = 0; i < 6; i++) begin
         wr(1'b1, 2'h3, {4'h0, 2'(i / 2 + 1), 2'h0});
         pins.drive(1, i % 2 == 0);
         rd(1'b1, 3'h4, b);
         chk(b[1], i / 2 == 2 || (i % 2 == 0) == (i / 2 == 0));
         wr(1'b1, 2'h2, 8'h02);
      end
      // lock after capture, overrun state, forced capture value
      wr(1'b1, 2'h2, 8'h10);
      pins.drive(1, 1'b1);
      rd16(1'b1, 3'h2, v0);
      pins.drive(1, 1'b0);
      rd16(1'b1, 3'h2, v1);
      chk(v1, v0);
      rd(1'b1, 3'h4, b);
      chk(b, 8'h12);
      wr(1'b1, 2'h3, 8'h0C);
      pins.drive(1, 1'b1);
      rd(1'b1, 3'h4, b);
      chk(b, 8'h32);
      wr(1'b1, 2'h2, 8'h12);
      rd(1'b1, 3'h4, b);
      chk(b, 8'h12);
      wr(1'b1, 2'h2, 8'h02);
      rd(1'b1, 3'h4, b);
      chk(b, 8'h00);
      wr(1'b1, 2'h2, 8'h08);
      rd16(1'b1, 3'h2, v0);
      chk(v0, cpc_pkg::CAP_FORCE);
      wr(1'b1, 2'h2, 8'h00);
      wr(1'b1, 2'h3, 8'h04);
      pins.drive(1, 1'b0);
      // divide by 16: ten counter steps in 160 clocks
      clockSelect = 2'h1;
      rd16(1'b0, 3'h0, v0);
      repeat (154) @(posedge core_clk);
      rd16(1'b0, 3'h0, v1);
      chk(v1 - v0, 16'h000A);
      clockSelect = 2'h0;
      wr(1'b0, 2'h3, 8'h04);
      rd16(1'b0, 3'h0, v0);
      pins.drive(0, 1'b1);
      rd16(1'b0, 3'h0, v1);
      rd16(1'b0, 3'h2, v2);
      chk(v2 >= v0 && v2 <= v1, 1'b1);
      moduleEnable = 1'b0;
      repeat (5) @(posedge core_clk);
      rd16(1'b0, 3'h0, v0);
      chk(v0, cpc_pkg::CNT_RST);
      rd16(1'b0, 3'h2, v0);
      chk(v0, cpc_pkg::CAP_RST);
      chk(pins.pinSeen[0], 1'b0);
      rd(1'b0, 3'h5, b);
      chk(b, 8'h04);
      pins.drive(1, 1'b1);
      rd(1'b1, 3'h4, b);
      chk(b[1], 1'b0);
      moduleEnable = 1'b1;
      repeat (100) @(posedge core_clk);
      #1 ovfCount = 0;
      repeat (65536) @(posedge core_clk);
      chk(16'(ovfCount), 16'h0001);
      rd(1'b0, 3'h4, b);
      chk(b[0], 1'b1);
      rd(1'b1, 3'h4, b);
      chk(b[0], 1'b1);
      chk(16'(cmpCount), 16'h0004);
      conclude();
   end
endmodule // cpc_capture_compare_module_bench
`default_nettype wire
